//--- lpmc_pkg.sv
package lpmc_pkg;
   localparam logic [7:0] LPMC_OFF_CTRL = 8'h00;
   localparam logic [7:0] LPMC_OFF_STS = 8'h04;
   // control register fields
   localparam int LPMC_CTRL_LPSEL = 0;
   localparam int LPMC_CTRL_PDSEL = 1;
   localparam int LPMC_CTRL_WUCLR = 2;
   localparam int LPMC_CTRL_SBCLR = 3;
   localparam int LPMC_CTRL_PVDEN = 4;
   localparam int LPMC_CTRL_PLSEL_LO = 5;
   localparam int LPMC_CTRL_BPWEN = 8;
   localparam logic [31:0] LPMC_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] LPMC_CTRL_WMASK = 32'h0000_01F3;
   // status register fields
   localparam int LPMC_STS_WUEF = 0;
   localparam int LPMC_STS_SBF = 1;
   localparam int LPMC_STS_PVDO = 2;
   localparam int LPMC_STS_WKCFG = 8;
   localparam logic [31:0] LPMC_STS_RESET = 32'h0000_0000;
   // wake flag clear takes effect after two system clocks
   localparam int LPMC_WUCLR_DELAY = 2;
   // timing: clock period and wake-up latencies
   localparam int LPMC_CLK_PERIOD_NS = 100;
   localparam int LPMC_HSI_START_NS = 2000;
   localparam int LPMC_REG_WAKE_NS = 3000;
   localparam int LPMC_CHIP_RESET_NS = 100000;
   localparam int LPMC_HSI_START_CYC = (LPMC_HSI_START_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
   localparam int LPMC_REG_WAKE_CYC = (LPMC_REG_WAKE_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
   localparam int LPMC_CHIP_RESET_CYC = (LPMC_CHIP_RESET_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      LPMC_RUN = 3'b000,
      LPMC_SLEEP = 3'b001,
      LPMC_STOP = 3'b010,
      LPMC_STOP_WAKE = 3'b011,
      LPMC_STANDBY = 3'b100,
      LPMC_SB_WAKE = 3'b101
   } lpmc_state_t;
endpackage

//--- lpmc_delay.sv
`timescale 1ns/1ps
// loadable down counter, done is a one-cycle pulse
module lpmc_delay #(
   parameter int WIDTH = 16
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   output logic done
);
   logic [WIDTH-1:0] cnt_r;
   logic busy_r;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt_r <= count;
            busy_r <= 1'b1;
         end else if (busy_r) begin
            if (cnt_r <= 1) begin
               busy_r <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule

//--- lpmc_ctrl.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module lpmc_ctrl
   import lpmc_pkg::*;
#(
   parameter int STOP_WAKE_CYC = LPMC_HSI_START_CYC + LPMC_REG_WAKE_CYC,
   parameter int STANDBY_WAKE_CYC = LPMC_CHIP_RESET_CYC
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic reg_sel,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic wfi_exec,
   input wire logic wfe_exec,
   input wire logic deep_sleep_select,
   input wire logic sleep_on_isr_exit,
   input wire logic isr_return,
   input wire logic irq_pending,
   input wire logic wake_event,
   input wire logic wakeup_pin,
   input wire logic rtc_wake,
   input wire logic external_reset_pin_n,
   input wire logic independent_watchdog_rst,
   input wire logic pvd_below,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic regulator_lowpower,
   output logic core_power_off,
   output logic wake_by_irq,
   output logic wake_by_event,
   output logic chip_restart,
   output logic [2:0] power_mode
);
   lpmc_state_t state_r, state_nxt;
   logic [31:0] ctrl_r;
   logic wuef_r, sbf_r, wkcfg_r;
   logic wfe_entry_r, pending_sleep_r, stop_lp_r;
   logic [1:0] wuclr_r;
   logic [2:0] pin_sync_r, external_reset_pin_sync_r, rtc_sync_r, pvd_sync_r;
   logic pin_rise, external_reset_pin_low, rtc_on, wait_exec, wake_cond, dly_load, dly_done;
   logic [31:0] dly_count;
   logic wr_ctrl, wr_sts;

   //////////////////////////////////////////////////////////////////////////
   // pin synchronisers, bit 0 only feeds bit 1
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pin_sync_r <= 3'h0;
         external_reset_pin_sync_r <= 3'h7;
         rtc_sync_r <= 3'h0;
         pvd_sync_r <= 3'h0;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], wakeup_pin};
         external_reset_pin_sync_r <= {external_reset_pin_sync_r[1:0], external_reset_pin_n};
         rtc_sync_r <= {rtc_sync_r[1:0], rtc_wake};
         pvd_sync_r <= {pvd_sync_r[1:0], pvd_below};
      end
   end
   assign pin_rise = pin_sync_r[1] & ~pin_sync_r[2];
   assign external_reset_pin_low = ~external_reset_pin_sync_r[1];
   assign rtc_on = rtc_sync_r[1];

   //////////////////////////////////////////////////////////////////////////
   // register access
   assign wr_ctrl = reg_sel && reg_write && reg_addr == LPMC_OFF_CTRL;
   assign wr_sts = reg_sel && reg_write && reg_addr == LPMC_OFF_STS;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= LPMC_CTRL_RESET;
      end else if (state_r == LPMC_SB_WAKE && dly_done) begin
         ctrl_r <= LPMC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= reg_wdata & LPMC_CTRL_WMASK;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wkcfg_r <= 1'b0;
      end else if (wr_sts) begin
         wkcfg_r <= reg_wdata[LPMC_STS_WKCFG];
      end
   end

   // wake flag clear lands two clocks after the write
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wuclr_r <= 2'h0;
      end else begin
         wuclr_r <= {wuclr_r[0], wr_ctrl & reg_wdata[LPMC_CTRL_WUCLR]};
      end
   end

   // set wins over clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wuef_r <= 1'b0;
      end else if ((pin_rise && wkcfg_r) || rtc_on) begin
         wuef_r <= 1'b1;
      end else if (wuclr_r[LPMC_WUCLR_DELAY-1]) begin
         wuef_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sbf_r <= 1'b0;
      end else if (state_r == LPMC_STANDBY) begin
         sbf_r <= 1'b1;
      end else if (wr_ctrl && reg_wdata[LPMC_CTRL_SBCLR]) begin
         sbf_r <= 1'b0;
      end
   end

   always_comb begin
      reg_rdata = 32'h0000_0000;
      if (reg_addr == LPMC_OFF_CTRL) begin
         reg_rdata = ctrl_r;
      end else if (reg_addr == LPMC_OFF_STS) begin
         reg_rdata[LPMC_STS_WUEF] = wuef_r;
         reg_rdata[LPMC_STS_SBF] = sbf_r;
         reg_rdata[LPMC_STS_PVDO] = pvd_sync_r[1] & ctrl_r[LPMC_CTRL_PVDEN] & (state_r != LPMC_STANDBY);
         reg_rdata[LPMC_STS_WKCFG] = wkcfg_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // mode sequencer
   assign wait_exec = wfi_exec | wfe_exec;
   assign wake_cond = wfe_entry_r ? wake_event : irq_pending;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pending_sleep_r <= 1'b0;
      end else if (state_r == LPMC_RUN && wait_exec && sleep_on_isr_exit && !isr_return) begin
         pending_sleep_r <= 1'b1;
      end else if (isr_return || state_r != LPMC_RUN) begin
         pending_sleep_r <= 1'b0;
      end
   end

   always_comb begin
      state_nxt = state_r;
      dly_load = 1'b0;
      dly_count = 32'h0000_0000;
      case (state_r)
         LPMC_RUN: begin
            if ((wait_exec && !sleep_on_isr_exit) || (pending_sleep_r && isr_return)) begin
               if (!deep_sleep_select) begin
                  state_nxt = LPMC_SLEEP;
               end else if (!ctrl_r[LPMC_CTRL_PDSEL]) begin
                  state_nxt = LPMC_STOP;
               end else if (!wuef_r) begin
                  state_nxt = LPMC_STANDBY;
               end
            end
         end
         LPMC_SLEEP: begin
            if (wake_cond) begin
               state_nxt = LPMC_RUN;
            end
         end
         LPMC_STOP: begin
            if (wake_cond) begin
               state_nxt = LPMC_STOP_WAKE;
               dly_load = 1'b1;
               dly_count = stop_lp_r ? 32'(STOP_WAKE_CYC) : 32'(LPMC_HSI_START_CYC);
            end
         end
         LPMC_STOP_WAKE: begin
            if (dly_done) begin
               state_nxt = LPMC_RUN;
            end
         end
         LPMC_STANDBY: begin
            if ((pin_rise && wkcfg_r) || rtc_on || external_reset_pin_low || independent_watchdog_rst) begin
               state_nxt = LPMC_SB_WAKE;
               dly_load = 1'b1;
               dly_count = 32'(STANDBY_WAKE_CYC);
            end
         end
         LPMC_SB_WAKE: begin
            if (dly_done) begin
               state_nxt = LPMC_RUN;
            end
         end
         default: state_nxt = LPMC_RUN;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= LPMC_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wfe_entry_r <= 1'b0;
         stop_lp_r <= 1'b0;
      end else if (state_r == LPMC_RUN && state_nxt != LPMC_RUN) begin
         wfe_entry_r <= wfe_exec & ~wfi_exec;
         stop_lp_r <= ctrl_r[LPMC_CTRL_LPSEL];
      end
   end

   lpmc_delay #(
      .WIDTH(32)
   ) u_delay (
      .clock(clock),
      .reset_n(reset_n),
      .load(dly_load),
      .count(dly_count),
      .done(dly_done)
   );

   //////////////////////////////////////////////////////////////////////////
   // registered mode outputs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         core_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         regulator_lowpower <= 1'b0;
         core_power_off <= 1'b0;
         chip_restart <= 1'b0;
         wake_by_irq <= 1'b0;
         wake_by_event <= 1'b0;
         power_mode <= 3'h0;
      end else begin
         core_clk_en <= (state_nxt == LPMC_RUN);
         periph_clk_en <= (state_nxt == LPMC_RUN) || (state_nxt == LPMC_SLEEP);
         regulator_lowpower <= ((state_nxt == LPMC_STOP) && (state_r == LPMC_STOP ? stop_lp_r
                              : ctrl_r[LPMC_CTRL_LPSEL]));
         core_power_off <= (state_nxt == LPMC_STANDBY) || (state_nxt == LPMC_SB_WAKE);
         chip_restart <= (state_r == LPMC_SB_WAKE) && dly_done;
         wake_by_irq <= (state_r != LPMC_RUN) && (state_r != LPMC_SB_WAKE) && (state_r != LPMC_STANDBY)
                        && (state_nxt == LPMC_RUN) && !wfe_entry_r;
         wake_by_event <= (state_r != LPMC_RUN) && (state_r != LPMC_SB_WAKE) && (state_r != LPMC_STANDBY)
                          && (state_nxt == LPMC_RUN) && wfe_entry_r;
         power_mode <= state_nxt;
      end
   end
endmodule

//--- lpmc_properties.sv
`timescale 1ns/1ps
module lpmc_properties
   import lpmc_pkg::*;
#(
   parameter int STOP_WAKE_CYC = 50,
   parameter int STANDBY_WAKE_CYC = 1000
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic wfi_exec,
   input wire logic deep_sleep_select,
   input wire logic sleep_on_isr_exit,
   input wire logic irq_pending,
   input wire logic wake_event,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic core_clk_en,
   input wire logic periph_clk_en,
   input wire logic core_power_off,
   input wire logic wake_by_irq,
   input wire logic wake_by_event,
   input wire logic chip_restart,
   input wire logic [2:0] power_mode
);
   int wait_cnt_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // cycles spent in a wake-up delay state
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n) wait_cnt_r <= 0;
      else wait_cnt_r <= (power_mode == LPMC_STOP_WAKE || power_mode == LPMC_SB_WAKE) ? wait_cnt_r + 1 : 0;
   sleep_entry_a: assert property (power_mode == LPMC_RUN && wfi_exec && !deep_sleep_select
      && !sleep_on_isr_exit |=> power_mode == LPMC_SLEEP && !core_clk_en) else $error("no sleep entry");
   sleep_gate_a: assert property (power_mode == LPMC_SLEEP |-> periph_clk_en && !core_clk_en)
      else $error("sleep clock gating wrong");
   stop_gate_a: assert property (power_mode == LPMC_STOP |-> !periph_clk_en && !core_clk_en)
      else $error("stop clock gating wrong");
   sleep_hold_a: assert property (power_mode == LPMC_SLEEP && !irq_pending && !wake_event |=> $stable(power_mode))
      else $error("sleep left without cause");
   sleep_wake_a: assert property (power_mode == LPMC_SLEEP ##1 power_mode == LPMC_RUN
      |-> core_clk_en && (wake_by_irq != wake_by_event)) else $error("sleep wake wrong");
   standby_off_a: assert property (power_mode == LPMC_STANDBY |-> core_power_off && !periph_clk_en)
      else $error("standby not powered off");
   restart_a: assert property (power_mode == LPMC_SB_WAKE ##1 power_mode == LPMC_RUN |-> chip_restart)
      else $error("no restart after standby");
   stop_time_a: assert property (power_mode == LPMC_STOP_WAKE |-> wait_cnt_r <= STOP_WAKE_CYC + LPMC_HSI_START_CYC)
      else $error("stop wake too long");
   sb_time_a: assert property (power_mode == LPMC_SB_WAKE |-> wait_cnt_r <= STANDBY_WAKE_CYC + 1)
      else $error("standby wake too long");
   unmapped_read_a: assert property (reg_addr != LPMC_OFF_CTRL && reg_addr != LPMC_OFF_STS |-> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind lpmc_ctrl lpmc_properties #(.STOP_WAKE_CYC(STOP_WAKE_CYC), .STANDBY_WAKE_CYC(STANDBY_WAKE_CYC)) props_u (
   .clock(clock),
   .reset_n(reset_n),
   .wfi_exec(wfi_exec),
   .deep_sleep_select(deep_sleep_select),
   .sleep_on_isr_exit(sleep_on_isr_exit),
   .irq_pending(irq_pending),
   .wake_event(wake_event),
   .reg_addr(reg_addr),
   .reg_rdata(reg_rdata),
   .core_clk_en(core_clk_en),
   .periph_clk_en(periph_clk_en),
   .core_power_off(core_power_off),
   .wake_by_irq(wake_by_irq),
   .wake_by_event(wake_by_event),
   .chip_restart(chip_restart),
   .power_mode(power_mode)
);

//--- lpmc_core_model.sv
`timescale 1ns/1ps
module lpmc_core_model (
   input wire logic clock,
   input wire logic core_clk_en,
   output logic wfi_exec,
   output logic wfe_exec,
   output logic deep_sleep_select,
   output logic sleep_on_isr_exit,
   output logic isr_return,
   output logic irq_pending
);
   initial {wfi_exec, wfe_exec, deep_sleep_select, sleep_on_isr_exit, isr_return, irq_pending} = 6'h00;
   task automatic wait_instr(input logic wait_for_event_instr, input logic deep, input logic on_exit);
      @(posedge clock);
      deep_sleep_select <= deep;
      sleep_on_isr_exit <= on_exit;
      wfi_exec <= !wait_for_event_instr;
      wfe_exec <= wait_for_event_instr;
      @(posedge clock);
      wfi_exec <= 1'b0;
      wfe_exec <= 1'b0;
   endtask
   task automatic raise_irq;
      @(posedge clock);
      irq_pending <= 1'b1;
   endtask
   // handler runs only once the core clock is back
   always @(posedge clock) begin
      isr_return <= 1'b0;
      if (irq_pending && core_clk_en) begin
         irq_pending <= 1'b0;
         isr_return <= 1'b1;
      end
   end
endmodule

//--- low_power_mode_controller_tb_top.sv
`timescale 1ns/1ps
module low_power_mode_controller_tb_top
   import lpmc_pkg::*;
;
   logic clock, reset_n, reg_sel, reg_write, wake_event, pvd_below, core_clk_en, periph_clk_en;
   logic wfi_exec, wfe_exec, deep_sleep_select, sleep_on_isr_exit, isr_return, irq_pending;
   logic regulator_lowpower, core_power_off, wake_by_irq, wake_by_event, chip_restart;
   logic [2:0] power_mode;
   logic [3:0] srcs;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   int miscompares, n_tests, cycles, n_irq_wake, n_ev_wake, n_restart;
   lpmc_ctrl #(.STOP_WAKE_CYC(3), .STANDBY_WAKE_CYC(5)) dut_u (.independent_watchdog_rst(srcs[0]),
      .external_reset_pin_n(~srcs[1]), .rtc_wake(srcs[2]), .wakeup_pin(srcs[3]), .*);
   lpmc_core_model core_u (.*);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   // tally of one-cycle wake and restart pulses
   always @(negedge clock) begin
      if (wake_by_irq === 1'b1) n_irq_wake++;
      if (wake_by_event === 1'b1) n_ev_wake++;
      if (chip_restart === 1'b1) n_restart++;
   end
   function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
      return d & LPMC_CTRL_WMASK;
   endfunction
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
      n_tests++;
      if (got !== e) begin
         $display("ERROR %s expected %h seen %h", what, e, got);
         miscompares++;
      end
   endtask
   // a write stays up until the next access takes it down
   task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic we);
      @(posedge clock);
      reg_sel <= we;
      reg_write <= we;
      reg_addr <= a;
      reg_wdata <= d;
      @(negedge clock);
      if (!we) chk("reg_rdata", d, reg_rdata);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      for (int i = 0; i < 60; i++) begin
         @(negedge clock);
         if (power_mode === m) break;
      end
      chk("power_mode", 32'(m), 32'(power_mode));
   endtask
   task automatic pulse(input logic [3:0] s, input logic ev);
      @(posedge clock);
      srcs <= s;
      wake_event <= ev;
      repeat (4) @(posedge clock);
      srcs <= 4'h0;
      wake_event <= 1'b0;
   endtask
   initial begin
      {reset_n, reg_sel, reg_write, wake_event, pvd_below, srcs, reg_addr, reg_wdata} = '0;
      {miscompares, n_tests, cycles} = '0;
      void'($urandom(32'h98F6));
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      bus(LPMC_OFF_CTRL, LPMC_CTRL_RESET, 1'b0);
      bus(LPMC_OFF_STS, LPMC_STS_RESET, 1'b0);
      repeat (6) begin
         v = $urandom;
         bus(LPMC_OFF_CTRL, v, 1'b1);
         bus(LPMC_OFF_CTRL, exp_ctrl(v), 1'b0);
         bus({v[7:2], 2'b11}, 32'h0, 1'b0);
      end
      bus(LPMC_OFF_CTRL, 32'h0, 1'b1);
      bus(LPMC_OFF_CTRL, 32'h0, 1'b0);
      for (int w = 0; w < 2; w++) begin
         core_u.wait_instr(w[0], 1'b0, 1'b0);
         wait_mode(LPMC_SLEEP);
         chk("core_clk_en", 32'h0, 32'(core_clk_en));
         chk("periph_clk_en", 32'h1, 32'(periph_clk_en));
         core_u.raise_irq();
         if (w == 1) begin
            repeat (3) @(negedge clock);
            chk("power_mode", 32'(LPMC_SLEEP), 32'(power_mode));
            pulse(4'h0, 1'b1);
         end
         wait_mode(LPMC_RUN);
         chk("core_clk_en", 32'h1, 32'(core_clk_en));
         chk("periph_clk_en", 32'h1, 32'(periph_clk_en));
      end
      chk("n_irq_wake", 32'h1, 32'(n_irq_wake));
      chk("n_ev_wake", 32'h1, 32'(n_ev_wake));
      core_u.wait_instr(1'b0, 1'b0, 1'b1);
      wait_mode(LPMC_RUN);
      core_u.raise_irq();
      wait_mode(LPMC_SLEEP);
      @(posedge clock);
      reset_n <= 1'b0;
      @(posedge clock);
      reset_n <= 1'b1;
      wait_mode(LPMC_RUN);
      for (int lp = 1; lp >= 0; lp--) begin
         bus(LPMC_OFF_CTRL, 32'(lp), 1'b1);
         bus(LPMC_OFF_CTRL, 32'(lp), 1'b0);
         core_u.wait_instr(1'b0, 1'b1, 1'b0);
         wait_mode(LPMC_STOP);
         chk("regulator_lowpower", 32'(lp), 32'(regulator_lowpower));
         chk("periph_clk_en", 32'h0, 32'(periph_clk_en));
         core_u.raise_irq();
         wait_mode(LPMC_RUN);
      end
      @(negedge clock);
      chk("n_irq_wake", 32'h3, 32'(n_irq_wake));
      bus(LPMC_OFF_STS, 32'h100, 1'b1);
      for (int s = 0; s < 4; s++) begin
         bus(LPMC_OFF_CTRL, 32'h6, 1'b1);
         bus(LPMC_OFF_CTRL, 32'h2, 1'b0);
         repeat (2) @(posedge clock);
         core_u.wait_instr(s[0], 1'b1, 1'b0);
         wait_mode(LPMC_STANDBY);
         chk("core_power_off", 32'h1, 32'(core_power_off));
         bus(LPMC_OFF_STS, 32'h102, 1'b0);
         pulse(4'h1 << s, 1'b0);
         wait_mode(LPMC_RUN);
         bus(LPMC_OFF_CTRL, LPMC_CTRL_RESET, 1'b0);
      end
      chk("n_restart", 32'h4, 32'(n_restart));
      chk("n_irq_wake", 32'h3, 32'(n_irq_wake));
      bus(LPMC_OFF_CTRL, 32'h2, 1'b1);
      bus(LPMC_OFF_STS, 32'h103, 1'b0);
      core_u.wait_instr(1'b0, 1'b1, 1'b0);
      wait_mode(LPMC_RUN);
      bus(LPMC_OFF_CTRL, 32'hC, 1'b1);
      bus(LPMC_OFF_STS, 32'h101, 1'b0);
      bus(LPMC_OFF_STS, 32'h101, 1'b0);
      bus(LPMC_OFF_STS, 32'h100, 1'b0);
      summarize();
   end
endmodule
